// ==== logic/wakseq_top.sv ====
// Wake activation sequencer with DRAM sleep control and AHB-Lite registers.
// Notes on behaviour
// - Switch pulses indicator, samples inhibit, releases.
// - Inhibit high: release peripherals, start cold reset.
// - Inhibit low: set flag, shut down again.
// - Switch activation never sets switch flag.
// - Card busy starts the same sequence.
// - Pin wakes only when its enable set.
// - Clock-domain reset clears pin enables.
// - Pin trigger sets pin flag either way.
// - Pins and carrier ignored during indicator.
// - Carrier detect starts the same sequence.
// - Carrier bit shows live pin level.
// - Carrier frozen while switch held down.
// - Carrier wake records no cause flag.
// - Timer alarm starts the same sequence.
// - Alarm held off until indicator ends.
// - DRAM register drives pins, reports status.
// - Suspend: burst refresh if enabled, self-refresh.
// - Ready bit set after self-refresh entry.
// - Stop bit halts memory clock.
// - Latch bit freezes DRAM pins.
// - Indicator length from wait setting, default.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module wakseq_top #(
  parameter int TICK_CYCLES = wakseq_pkg::WAIT_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Wake sources
  input wire wakseq_pkg::wakseq_pins_t pins,
  input wire logic timer_alarm,
  input wire logic hibernate_req,
  // Power sequencing
  output logic wake_indicator,
  output logic periph_reset_release,
  output logic cold_reset_start,
  output logic shutdown_start,
  // Memory controller
  input wire logic burst_refresh_en,
  input wire logic burst_done,
  input wire logic selfrefresh_ack,
  output wakseq_pkg::wakseq_mc_t mc_ctrl
);
  import wakseq_pkg::*;

  typedef enum logic [1:0] {W_SLEEP, W_IND, W_RUN} wakseq_state_t;
  typedef enum logic [1:0] {M_IDLE, M_BURST, M_ENTER, M_READY} wakseq_mstate_t;

  wakseq_pins_t pin_s;
  wakseq_state_t state_reg;
  wakseq_mstate_t mstate_reg;
  logic [15:0] gpio_prev_reg, pin_en_reg;
  logic switch_prev_reg, busy_prev_reg, carrier_ref_reg, alarm_prev_reg, alarm_pend_reg;
  logic [7:0] wait_reg, unit_cnt_reg, wr_addr_reg, wait_units;
  logic [2:0] dram_reg;
  logic low_cell_flag_reg, switch_flag_reg, pin_flag_reg, wr_pend_reg;
  logic [31:0] tick_cnt_reg, cause_rd;
  logic addr_phase, pin_trig, switch_trig, busy_trig, carrier_trig, alarm_trig, any_trig;
  logic ind_last, cause_wr;

  wakseq_sync #(
    .WIDTH(20),
    .INIT(PINS_IDLE)
  ) u_pin_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din(pins),
    .dout(pin_s)
  );

  // Bus side: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  assign cause_wr = wr_pend_reg && (wr_addr_reg == ADDR_CAUSE);

  always_comb begin
    cause_rd = 32'h0000_0000;
    cause_rd[CAUSE_LOW_CELL] = low_cell_flag_reg;
    cause_rd[CAUSE_SWITCH] = switch_flag_reg;
    cause_rd[CAUSE_PIN_WAKE] = pin_flag_reg;
    cause_rd[CAUSE_CARRIER] = !pin_s.carrier_detect_n;
  end

  // Read data is captured at the address phase; unmapped offsets read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        ADDR_CAUSE: hrdata <= cause_rd;
        ADDR_WAIT: hrdata <= {24'h00_0000, wait_reg};
        ADDR_PIN_EN: hrdata <= {16'h0000, pin_en_reg};
        ADDR_DRAM: hrdata <= {28'h000_0000, mstate_reg == M_READY, dram_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Software configuration; the bus reset doubles as the clock-domain reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_en_reg <= PIN_EN_RESET;
      wait_reg <= WAIT_RESET;
      dram_reg <= DRAM_CTRL_RESET;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        ADDR_WAIT: wait_reg <= hwdata[7:0];
        ADDR_PIN_EN: pin_en_reg <= hwdata[15:0];
        ADDR_DRAM: dram_reg <= hwdata[2:0];
        default: dram_reg <= dram_reg;
      endcase
    end
  end

  // Edge detection on the filtered pins and on the unfiltered timer alarm.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_prev_reg <= 16'h0000;
      switch_prev_reg <= 1'b0;
      busy_prev_reg <= 1'b1;
      alarm_prev_reg <= 1'b0;
    end else begin
      gpio_prev_reg <= pin_s.gpio;
      switch_prev_reg <= pin_s.power_switch;
      busy_prev_reg <= pin_s.card_busy_n;
      alarm_prev_reg <= timer_alarm;
    end
  end

  // The carrier reference is frozen while the switch is held, so only a net change is seen.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carrier_ref_reg <= 1'b0;
    end else if (!pin_s.power_switch) begin
      carrier_ref_reg <= !pin_s.carrier_detect_n;
    end
  end

  // Pins and carrier are dropped while the indicator is on.
  assign pin_trig = (state_reg == W_SLEEP) && |(pin_s.gpio & ~gpio_prev_reg & pin_en_reg);
  assign switch_trig = (state_reg == W_SLEEP) && pin_s.power_switch && !switch_prev_reg;
  assign busy_trig = (state_reg == W_SLEEP) && !pin_s.card_busy_n && busy_prev_reg;
  assign carrier_trig = (state_reg == W_SLEEP) && !pin_s.power_switch &&
                        !pin_s.carrier_detect_n && !carrier_ref_reg;
  assign alarm_trig = (state_reg == W_SLEEP) && alarm_pend_reg;
  assign any_trig = pin_trig || switch_trig || busy_trig || carrier_trig || alarm_trig;

  // An alarm is remembered while the indicator is on and delivered after it ends in a shutdown; a cold reset drops it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_pend_reg <= 1'b0;
    end else if (timer_alarm && !alarm_prev_reg && state_reg != W_RUN) begin
      alarm_pend_reg <= 1'b1;
    end else if (state_reg != W_IND) begin
      alarm_pend_reg <= 1'b0;
    end
  end

  // Indicator duration: wait setting times the unit, zero treated as one unit.
  assign wait_units = (wait_reg == 8'h00) ? 8'h01 : wait_reg;
  assign ind_last = (unit_cnt_reg == wait_units - 8'h01) &&
                    (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= 32'h0000_0000;
      unit_cnt_reg <= 8'h00;
    end else if (state_reg != W_IND) begin
      tick_cnt_reg <= 32'h0000_0000;
      unit_cnt_reg <= 8'h00;
    end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h0000_0000;
      unit_cnt_reg <= unit_cnt_reg + 8'h01;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // Wake sequence. Reset acts as a cold start with the core running.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= W_RUN;
      wake_indicator <= 1'b0;
      periph_reset_release <= 1'b1;
      cold_reset_start <= 1'b0;
      shutdown_start <= 1'b0;
    end else begin
      cold_reset_start <= 1'b0;
      shutdown_start <= 1'b0;
      case (state_reg)
        W_SLEEP: begin
          if (any_trig) begin
            state_reg <= W_IND;
            wake_indicator <= 1'b1;
          end
        end
        W_IND: begin
          if (ind_last) begin
            wake_indicator <= 1'b0;
            if (pin_s.low_cell_inhibit) begin
              state_reg <= W_RUN;
              periph_reset_release <= 1'b1;
              cold_reset_start <= 1'b1;
            end else begin
              state_reg <= W_SLEEP;
              shutdown_start <= 1'b1;
            end
          end
        end
        W_RUN: begin
          if (hibernate_req) begin
            state_reg <= W_SLEEP;
            periph_reset_release <= 1'b0;
            shutdown_start <= 1'b1;
          end
        end
        default: begin
          state_reg <= W_SLEEP;
          wake_indicator <= 1'b0;
        end
      endcase
    end
  end

  // Cause flags: write one to clear, a hardware set in the same cycle wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cell_flag_reg <= 1'b0;
    end else if (state_reg == W_IND && ind_last && !pin_s.low_cell_inhibit) begin
      low_cell_flag_reg <= 1'b1;
    end else if (cause_wr && hwdata[CAUSE_LOW_CELL]) begin
      low_cell_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_flag_reg <= 1'b0;
    end else if (pin_trig) begin
      pin_flag_reg <= 1'b1;
    end else if (cause_wr && hwdata[CAUSE_PIN_WAKE]) begin
      pin_flag_reg <= 1'b0;
    end
  end

  // The switch flag belongs to the running interrupt path; activation never sets it.
  // A carrier wake likewise records no cause, leaving software to read the live level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_flag_reg <= 1'b0;
    end else if (cause_wr && hwdata[CAUSE_SWITCH]) begin
      switch_flag_reg <= 1'b0;
    end
  end

  // Self-refresh entry, with an optional burst first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mstate_reg <= M_IDLE;
    end else if (!dram_reg[DRAM_SUSPEND]) begin
      mstate_reg <= M_IDLE;
    end else begin
      case (mstate_reg)
        M_IDLE: mstate_reg <= burst_refresh_en ? M_BURST : M_ENTER;
        M_BURST: if (burst_done) mstate_reg <= M_ENTER;
        M_ENTER: if (selfrefresh_ack) mstate_reg <= M_READY;
        M_READY: mstate_reg <= M_READY;
        default: mstate_reg <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_ctrl <= '{burst_req: 1'b0, selfref_req: 1'b0, clk_run: 1'b1, pins_hold: 1'b0};
    end else begin
      mc_ctrl.burst_req <= dram_reg[DRAM_SUSPEND] && mstate_reg == M_BURST;
      mc_ctrl.selfref_req <= dram_reg[DRAM_SUSPEND] &&
                             (mstate_reg == M_ENTER || mstate_reg == M_READY);
      mc_ctrl.clk_run <= !dram_reg[DRAM_STOP_CLK];
      mc_ctrl.pins_hold <= dram_reg[DRAM_PIN_LATCH];
    end
  end

  // Checks.
  property p_ind_start;
    @(posedge hclk) disable iff (!hresetn)
      $rose(wake_indicator) |-> $past(state_reg) == W_SLEEP && $past(any_trig);
  endproperty
  a_ind_start: assert property (p_ind_start) else $error("indicator rose without a wake source");

  property p_cold_ok;
    @(posedge hclk) disable iff (!hresetn)
      $fell(wake_indicator) |-> cold_reset_start == $past(pin_s.low_cell_inhibit);
  endproperty
  a_cold_ok: assert property (p_cold_ok) else $error("cold reset does not follow inhibit level");

  property p_low_cell;
    @(posedge hclk) disable iff (!hresetn)
      $fell(wake_indicator) && !cold_reset_start |-> shutdown_start ##1 low_cell_flag_reg;
  endproperty
  a_low_cell: assert property (p_low_cell) else $error("blocked wake did not flag and shut down");

  property p_no_switch_flag;
    @(posedge hclk) disable iff (!hresetn)
      !switch_flag_reg;
  endproperty
  a_no_switch_flag: assert property (p_no_switch_flag) else $error("switch flag was set");

  property p_pin_flag;
    @(posedge hclk) disable iff (!hresetn)
      pin_trig |-> wake_indicator == 1'b0 ##1 pin_flag_reg && wake_indicator;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin wake not recorded");

  property p_alarm_held;
    @(posedge hclk) disable iff (!hresetn)
      $fell(wake_indicator) && alarm_pend_reg && !cold_reset_start |=> wake_indicator;
  endproperty
  a_alarm_held: assert property (p_alarm_held) else $error("held alarm not delivered");

  property p_ready;
    @(posedge hclk) disable iff (!hresetn)
      $rose(mstate_reg == M_READY) |-> $past(selfrefresh_ack) && $past(mstate_reg) == M_ENTER;
  endproperty
  a_ready: assert property (p_ready) else $error("ready without self-refresh entry");

  property p_stop_clk;
    @(posedge hclk) disable iff (!hresetn)
      dram_reg[DRAM_STOP_CLK] [*2] |-> !mc_ctrl.clk_run;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("memory clock still runs");

  property p_latch;
    @(posedge hclk) disable iff (!hresetn)
      $rose(dram_reg[DRAM_PIN_LATCH]) |=> mc_ctrl.pins_hold;
  endproperty
  a_latch: assert property (p_latch) else $error("DRAM pins not frozen");

endmodule : wakseq_top

// ==== logic/wakseq_pkg.sv ====
// Constants, register map and carrier types of the wake activation sequencer.
package wakseq_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_WAIT = 8'h04;
  localparam logic [7:0] ADDR_PIN_EN = 8'h08;
  localparam logic [7:0] ADDR_DRAM = 8'h0C;

  // Field positions of the cause register.
  localparam int CAUSE_LOW_CELL = 0;
  localparam int CAUSE_SWITCH = 1;
  localparam int CAUSE_PIN_WAKE = 2;
  localparam int CAUSE_CARRIER = 3;

  // Field positions of the DRAM sleep control register.
  localparam int DRAM_SUSPEND = 0;
  localparam int DRAM_STOP_CLK = 1;
  localparam int DRAM_PIN_LATCH = 2;
  localparam int DRAM_READY = 3;

  // Reset values.
  localparam logic [15:0] PIN_EN_RESET = 16'h0000;
  localparam logic [2:0] DRAM_CTRL_RESET = 3'h0;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // Timing: the wait setting counts units of 31.25 ms.
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAIT_UNIT_NS = 31_250_000;
  localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_NS / CLK_PERIOD_NS;
  localparam int WAIT_DEFAULT_NS = 343_750_000;
  localparam logic [7:0] WAIT_RESET = 8'(WAIT_DEFAULT_NS / WAIT_UNIT_NS);

  // Wake pins as they arrive from the board.
  typedef struct packed {
    logic power_switch;
    logic card_busy_n;
    logic carrier_detect_n;
    logic low_cell_inhibit;
    logic [15:0] gpio;
  } wakseq_pins_t;

  localparam wakseq_pins_t PINS_IDLE = 20'h6_0000;

  // Controls toward the memory controller and DRAM pads.
  typedef struct packed {
    logic burst_req;
    logic selfref_req;
    logic clk_run;
    logic pins_hold;
  } wakseq_mc_t;

endpackage : wakseq_pkg

// ==== logic/wakseq_sync.sv ====
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module wakseq_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit only moves once stages two and three agree, which rejects a one-cycle glitch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= INIT;
    end else begin
      dout <= (s3_reg & ~(s2_reg ^ s3_reg)) | (dout & (s2_reg ^ s3_reg));
    end
  end

endmodule : wakseq_sync

// ==== bench/wakseq_mem_model.sv ====
// Memory controller model answering the sleep handshake of the sequencer.
`timescale 1ns/10ps
module wakseq_mem_model #(
  parameter int DELAY = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Handshake
  input wire wakseq_pkg::wakseq_mc_t mc,
  output logic burst_done,
  output logic selfrefresh_ack
);
  import wakseq_pkg::*;
  int cnt;
  // The first answer comes DELAY+1 cycles after a request; the count restarts only when both requests drop. Answers drop with the request, so a design that
  // skips a wait or holds a request too long is not rescued.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      burst_done <= 1'b0;
      selfrefresh_ack <= 1'b0;
    end else if (!(mc.burst_req || mc.selfref_req)) begin
      cnt <= 0;
      burst_done <= 1'b0;
      selfrefresh_ack <= 1'b0;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end else begin
      burst_done <= mc.burst_req;
      selfrefresh_ack <= mc.selfref_req;
    end
  end
endmodule : wakseq_mem_model

// ==== bench/test_wake_activation_sequencer.sv ====
// Self-checking bench of the wake activation sequencer.
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module test_wake_activation_sequencer;
  import wakseq_pkg::*;
  localparam int TICK = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wakseq_pins_t pins;
  logic timer_alarm, hibernate_req, wake_indicator, periph_reset_release;
  logic cold_reset_start, shutdown_start, burst_refresh_en, burst_done, selfrefresh_ack;
  wakseq_mc_t mc_ctrl;
  int n_errors, check_count, n_ind, n_shut, n_burst, base;
  assign hready = hreadyout;

  wakseq_top #(.TICK_CYCLES(TICK)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
    .timer_alarm(timer_alarm), .hibernate_req(hibernate_req),
    .wake_indicator(wake_indicator), .periph_reset_release(periph_reset_release),
    .cold_reset_start(cold_reset_start), .shutdown_start(shutdown_start),
    .burst_refresh_en(burst_refresh_en), .burst_done(burst_done),
    .selfrefresh_ack(selfrefresh_ack), .mc_ctrl(mc_ctrl));
  wakseq_mem_model mem (.clk(hclk), .rst_n(hresetn), .mc(mc_ctrl), .burst_done(burst_done),
    .selfrefresh_ack(selfrefresh_ack));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge wake_indicator) n_ind++;
  always @(posedge hclk) begin
    if (shutdown_start === 1'b1) n_shut++;
    if (mc_ctrl.burst_req === 1'b1) n_burst++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // One single AHB-Lite transfer; read data is taken at the edge ending the data phase.
  // Waits are open ended on purpose; only the watchdog ends a hung transfer.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp, "register read")
  endtask : rd_chk

  task automatic sleep_now();
    base = n_shut;
    @(posedge hclk);
    hibernate_req <= 1'b1;
    @(posedge hclk);
    hibernate_req <= 1'b0;
    cyc(4);
    `CHK(n_shut - base, 1, "shutdown on hibernate")
    `CHK(periph_reset_release, 1'b0, "peripherals held in reset")
  endtask : sleep_now

  // Waits for the indicator, measures it and checks the outcome at its fall.
  // It returns one edge after the fall, so a held alarm that rises there is still measured whole.
  task automatic run_seq(input int len, input logic ok);
    int n;
    int w;
    n = 0;
    w = 0;
    #1;
    while (wake_indicator !== 1'b1 && w < 30) begin @(posedge hclk); #1; w++; end
    while (wake_indicator === 1'b1 && n < 2000) begin n++; @(posedge hclk); #1; end
    `CHK(n, len, "indicator length")
    `CHK(ok ? cold_reset_start : shutdown_start, 1'b1, "outcome pulse")
    `CHK(periph_reset_release, ok, "peripheral release")
    @(posedge hclk);
  endtask : run_seq

  task automatic poll_ready();
    int n;
    n = 0;
    do begin bus(1'b0, ADDR_DRAM, 32'h0000_0000); n++; end while (rd[3] !== 1'b1 && n < 30);
    `CHK(rd[3], 1'b1, "ready to stop clock")
  endtask : poll_ready

  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    #1_000_000;
    n_errors++;
    wrap_up();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    pins = PINS_IDLE;
    pins.low_cell_inhibit = 1'b1;
    timer_alarm = 1'b0;
    hibernate_req = 1'b0;
    burst_refresh_en = 1'b0;
    cyc(8);
    hresetn <= 1'b1;
    rd_chk(ADDR_CAUSE, 32'h0000_0000);
    rd_chk(ADDR_WAIT, 32'h0000_000B);
    rd_chk(ADDR_PIN_EN, 32'h0000_0000);
    rd_chk(ADDR_DRAM, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_0000);
    `CHK(hresp, HRESP_OKAY, "bus response")
    `CHK(hreadyout, 1'b1, "bus ready")
    // Switch wake at the default wait length, battery good.
    sleep_now();
    pins.power_switch <= 1'b1;
    run_seq(11 * TICK, 1'b1);
    pins.power_switch <= 1'b0;
    rd_chk(ADDR_CAUSE, 32'h0000_0000);
    // Card busy wake with a shortened wait and a low cell.
    bus(1'b1, ADDR_WAIT, 32'h0000_0002);
    sleep_now();
    pins.low_cell_inhibit <= 1'b0;
    pins.card_busy_n <= 1'b0;
    run_seq(2 * TICK, 1'b0);
    pins.card_busy_n <= 1'b1;
    rd_chk(ADDR_CAUSE, 32'h0000_0001);
    bus(1'b1, ADDR_CAUSE, 32'h0000_0001);
    rd_chk(ADDR_CAUSE, 32'h0000_0000);
    // A pin without its enable must not wake; with it, the pin flag is set.
    base = n_ind;
    pins.gpio[5] <= 1'b1;
    cyc(20);
    `CHK(n_ind, base, "disabled pin woke")
    bus(1'b1, ADDR_PIN_EN, 32'h0000_0020);
    rd_chk(ADDR_PIN_EN, 32'h0000_0020);
    pins.gpio[5] <= 1'b0;
    cyc(8);
    pins.gpio[5] <= 1'b1;
    run_seq(2 * TICK, 1'b0);
    rd_chk(ADDR_CAUSE, 32'h0000_0005);
    bus(1'b1, ADDR_CAUSE, 32'h0000_0005);
    pins.gpio[5] <= 1'b0;
    cyc(8);
    // Alarm and pin edge during the indicator; carrier change with the switch held.
    pins.power_switch <= 1'b1;
    fork
      run_seq(2 * TICK, 1'b0);
      begin
        cyc(6);
        timer_alarm <= 1'b1;
        pins.gpio[5] <= 1'b1;
        cyc(1);
        timer_alarm <= 1'b0;
      end
    join
    run_seq(2 * TICK, 1'b0);
    pins.carrier_detect_n <= 1'b0;
    base = n_ind;
    cyc(20);
    `CHK(n_ind, base, "edge seen while ignored")
    pins.low_cell_inhibit <= 1'b1;
    pins.power_switch <= 1'b0;
    run_seq(2 * TICK, 1'b1);
    rd_chk(ADDR_CAUSE, 32'h0000_0009);
    pins.carrier_detect_n <= 1'b1;
    cyc(8);
    rd_chk(ADDR_CAUSE, 32'h0000_0001);
    bus(1'b1, ADDR_CAUSE, 32'h0000_0007);
    // Two sources at once give one sequence.
    sleep_now();
    base = n_ind;
    pins.card_busy_n <= 1'b0;
    timer_alarm <= 1'b1;
    cyc(1);
    timer_alarm <= 1'b0;
    run_seq(2 * TICK, 1'b1);
    cyc(20);
    `CHK(n_ind - base, 1, "overlapping sequences")
    pins.card_busy_n <= 1'b1;
    // DRAM sleep with and without burst refresh.
    burst_refresh_en <= 1'b1;
    base = n_burst;
    bus(1'b1, ADDR_DRAM, 32'h0000_0001);
    poll_ready();
    `CHK(n_burst > base, 1'b1, "burst refresh missing")
    bus(1'b1, ADDR_DRAM, 32'h0000_0003);
    cyc(2);
    `CHK(mc_ctrl.clk_run, 1'b0, "memory clock still runs")
    bus(1'b1, ADDR_DRAM, 32'h0000_0007);
    cyc(2);
    `CHK(mc_ctrl.pins_hold, 1'b1, "pins not latched")
    rd_chk(ADDR_DRAM, 32'h0000_000F);
    bus(1'b1, ADDR_DRAM, 32'h0000_0000);
    cyc(4);
    burst_refresh_en <= 1'b0;
    base = n_burst;
    bus(1'b1, ADDR_DRAM, 32'h0000_0001);
    poll_ready();
    `CHK(n_burst, base, "unwanted burst refresh")
    bus(1'b1, ADDR_DRAM, 32'h0000_0000);
    // A second reset clears the pin enables and restores the wait.
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    rd_chk(ADDR_PIN_EN, 32'h0000_0000);
    rd_chk(ADDR_WAIT, 32'h0000_000B);
    wrap_up();
  end
endmodule : test_wake_activation_sequencer
